//--- src/lomc_gain_stepper.sv
// Soft-stepping of analog gain codes toward their programmed targets.
// Assumes step_en is a one-cycle pulse from a divider on core_clk.
`timescale 1ns/10ps
module lomc_gain_stepper #(
  parameter int NPATH = 9,
  parameter int W     = 7
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // Step pacing
  input  wire logic               step_en,
  // Programmed and applied codes, path i at bits [i*W +: W]
  input  wire logic [NPATH*W-1:0] target,
  output      logic [NPATH*W-1:0] applied,
  output      logic [NPATH-1:0]   pending
);

  genvar i;
  generate
    for (i = 0; i < NPATH; i++) begin : g_path
      // One code step per tick avoids zipper noise on large jumps
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          applied[i*W +: W] <= '0;
        end else if (step_en) begin
          if (applied[i*W +: W] < target[i*W +: W]) begin
            applied[i*W +: W] <= applied[i*W +: W] + W'(1);
          end else if (applied[i*W +: W] > target[i*W +: W]) begin
            applied[i*W +: W] <= applied[i*W +: W] - W'(1);
          end
        end
      end
      // Path still moving
      assign pending[i] = (applied[i*W +: W] != target[i*W +: W]);
    end
  endgenerate

endmodule // lomc_gain_stepper

//--- src/lomc_pkg.sv
// Package for the line-output mixer control register bank.
// Assumes the control interface presents byte registers on page zero.
package lomc_pkg;

  // Widths
  localparam int REG_W  = 8;
  localparam int ADDR_W = 7;
  localparam int VOL_W  = 7;
  localparam int LVL_W  = 4;
  localparam int NROUTE = 8;
  localparam int NPATH  = NROUTE + 1;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_RIN_AMP_LEFT  = 7'h54;
  localparam logic [ADDR_W-1:0] ADDR_RDAC_LEFT     = 7'h55;
  localparam logic [ADDR_W-1:0] ADDR_LEFT_LEVEL    = 7'h56;
  localparam logic [ADDR_W-1:0] ADDR_LLINE2_RIGHT  = 7'h57;
  localparam logic [ADDR_W-1:0] ADDR_LIN_AMP_RIGHT = 7'h58;
  localparam logic [ADDR_W-1:0] ADDR_LDAC_RIGHT    = 7'h59;
  localparam logic [ADDR_W-1:0] ADDR_RLINE2_RIGHT  = 7'h5a;
  localparam logic [ADDR_W-1:0] ADDR_RIN_AMP_RIGHT = 7'h5b;
  localparam logic [ADDR_W-1:0] ADDR_RDAC_RIGHT    = 7'h5c;

  // Field positions
  localparam int BIT_ROUTE_EN = 7;
  localparam int VOL_MSB      = 6;
  localparam int LVL_MSB      = 7;
  localparam int LVL_LSB      = 4;
  localparam int BIT_UNMUTE   = 3;
  localparam int BIT_RSVD     = 2;
  localparam int BIT_PEND     = 1;
  localparam int BIT_PWR      = 0;

  // Reset values and largest level code
  localparam logic [REG_W-1:0] RST_ROUTE    = 8'h00;
  localparam logic [LVL_W-1:0] RST_LVL_CODE = 4'h0;
  localparam logic             RST_UNMUTE   = 1'b0;
  localparam logic             RST_PEND     = 1'b1;
  localparam logic             RST_PWR      = 1'b0;
  localparam logic [LVL_W-1:0] LVL_MAX_CODE = 4'h9;

  // Timing: one volume step per gain step period
  localparam int CLK_PERIOD_NS    = 40;
  localparam int GAIN_STEP_NS     = 1000;
  localparam int GAIN_STEP_CYCLES = (GAIN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

//--- src/lomc_regs.sv
// Register bank for the differential line-output mixers and left output level.
// Assumes the control interface decodes page zero and gives one-cycle strobes.
//
// How it works
// - Bit seven routes source to line output
// - Bits six to zero hold volume code
// - Level bits seven-four, one dB steps
// - Bit three zero mutes left output
// - Bit two reserved, reads zero
// - Bit one flags left gains not yet applied
// - Bit zero shows left driver powered up
// - Six right-output routing registers, 0x57-0x5c
`timescale 1ns/10ps
module lomc_regs
  import lomc_pkg::*;
#(
  parameter int STEP_CYCLES = lomc_pkg::GAIN_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic                                  core_clk,
  input  wire logic                                  rst_n,
  // Register port from the control interface
  input  wire logic [lomc_pkg::ADDR_W-1:0]           reg_addr,
  input  wire logic                                  reg_wr,
  input  wire logic [lomc_pkg::REG_W-1:0]            reg_wdata,
  input  wire logic                                  reg_rd,
  output      logic [lomc_pkg::REG_W-1:0]            reg_rdata,
  // Analog status pin
  input  wire logic                                  left_out_pwr_pin,
  // Analog mixer controls
  output      logic [lomc_pkg::NROUTE-1:0]           route_en,
  output      logic [lomc_pkg::NROUTE*lomc_pkg::VOL_W-1:0] route_vol,
  output      logic [lomc_pkg::LVL_W-1:0]            left_out_level,
  output      logic                                  left_out_unmute
);
  import lomc_pkg::*;

  // Address to routing slot; level register sits between left and right slots
  function automatic logic [3:0] route_slot(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_RIN_AMP_LEFT:  route_slot = 4'h0;
      ADDR_RDAC_LEFT:     route_slot = 4'h1;
      ADDR_LLINE2_RIGHT:  route_slot = 4'h2;
      ADDR_LIN_AMP_RIGHT: route_slot = 4'h3;
      ADDR_LDAC_RIGHT:    route_slot = 4'h4;
      ADDR_RLINE2_RIGHT:  route_slot = 4'h5;
      ADDR_RIN_AMP_RIGHT: route_slot = 4'h6;
      ADDR_RDAC_RIGHT:    route_slot = 4'h7;
      default:            route_slot = 4'hf;
    endcase
  endfunction

  logic [REG_W-1:0]         route_reg [NROUTE];
  logic [LVL_W-1:0]         level_code;
  logic                     unmute;
  logic                     pend_flag;
  logic                     pwr_s1, pwr_s2, pwr_s3, pwr_stable;
  logic [15:0]              step_cnt;
  logic                     step_tick;
  logic [NPATH*VOL_W-1:0]   target;
  logic [NPATH*VOL_W-1:0]   applied;
  logic [NPATH-1:0]         pending;
  logic [3:0]               wr_slot;
  logic                     left_wr;
  logic [REG_W-1:0]         next_rdata;

  assign wr_slot = route_slot(reg_addr);
  assign left_wr = reg_wr && (reg_addr == ADDR_RIN_AMP_LEFT || reg_addr == ADDR_RDAC_LEFT ||
                              reg_addr == ADDR_LEFT_LEVEL);

  // Routing registers: enable bit and volume code stored whole
  genvar g;
  generate
    for (g = 0; g < NROUTE; g++) begin : g_route
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          route_reg[g] <= RST_ROUTE;
        end else if (reg_wr && wr_slot == 4'(g)) begin
          route_reg[g] <= reg_wdata;
        end
      end
      assign route_en[g]                 = route_reg[g][BIT_ROUTE_EN];
      assign route_vol[g*VOL_W +: VOL_W] = applied[g*VOL_W +: VOL_W];
      assign target[g*VOL_W +: VOL_W]    = route_reg[g][VOL_MSB:0];
    end
  endgenerate

  // Level and mute; low bits of the write are dropped as read-only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_code <= RST_LVL_CODE;
      unmute     <= RST_UNMUTE;
    end else if (reg_wr && reg_addr == ADDR_LEFT_LEVEL) begin
      level_code <= reg_wdata[LVL_MSB:LVL_LSB]; // stored as written, host avoids 10-15
      unmute     <= reg_wdata[BIT_UNMUTE];
    end
  end
  assign target[NROUTE*VOL_W +: VOL_W] = {{(VOL_W-LVL_W){1'b0}}, level_code};
  assign left_out_level  = applied[NROUTE*VOL_W +: LVL_W];
  assign left_out_unmute = unmute;

  // Gain step divider
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt <= '0;
    end else if (step_cnt == 16'(STEP_CYCLES - 1)) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= step_cnt + 16'h0001;
    end
  end
  assign step_tick = (step_cnt == 16'(STEP_CYCLES - 1));

  lomc_gain_stepper #(
    .NPATH (NPATH),
    .W     (VOL_W)
  ) u_stepper (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .step_en  (step_tick),
    .target   (target),
    .applied  (applied),
    .pending  (pending)
  );

  // Pending flag: a left write sets it and wins over a settling tick
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_flag <= RST_PEND;
    end else if (left_wr) begin
      pend_flag <= 1'b1;
    end else if (step_tick) begin
      pend_flag <= pending[0] | pending[1] | pending[NROUTE];
    end
  end

  // Power pin synchroniser; the level moves only when stages two and three agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_s1     <= RST_PWR;
      pwr_s2     <= RST_PWR;
      pwr_s3     <= RST_PWR;
      pwr_stable <= RST_PWR;
    end else begin
      pwr_s1 <= left_out_pwr_pin;
      pwr_s2 <= pwr_s1;
      pwr_s3 <= pwr_s2;
      if (pwr_s2 == pwr_s3) begin
        pwr_stable <= pwr_s3;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == ADDR_LEFT_LEVEL) begin
      next_rdata = {level_code, unmute, 1'b0, pend_flag, pwr_stable};
    end else if (wr_slot != 4'hf) begin
      next_rdata = route_reg[wr_slot[2:0]];
    end
  end

  // Read data held until the next read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // Checks
  a_route_enable_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_RIN_AMP_LEFT |=> route_en[0] == $past(reg_wdata[7]))
    else $error("routing enable did not follow write");
  a_route_vol_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_RDAC_LEFT |=> route_reg[1][6:0] == $past(reg_wdata[6:0]))
    else $error("volume code not stored");
  a_level_code_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_LEFT_LEVEL |=> level_code == $past(reg_wdata[7:4]))
    else $error("level code not stored");
  a_mute_on_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_LEFT_LEVEL && !reg_wdata[3] |=> !left_out_unmute)
    else $error("output not muted");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_LEFT_LEVEL |=> reg_rdata[2] == 1'b0)
    else $error("reserved bit reads one");
  a_pend_set_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
    left_wr |=> pend_flag)
    else $error("pending flag not set by write");
  a_pend_settles: assert property (@(posedge core_clk) disable iff (!rst_n)
    step_tick && !left_wr && pending[1:0] == 2'b00 && !pending[8] |=> !pend_flag)
    else $error("pending flag stuck");
  a_power_report: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_LEFT_LEVEL |=> reg_rdata[0] == $past(pwr_stable))
    else $error("power status misreported");
  a_right_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_RDAC_RIGHT |=> route_reg[7] == $past(reg_wdata))
    else $error("right routing register misplaced");
  a_ro_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_LEFT_LEVEL && !reg_wdata[1] |=> pend_flag)
    else $error("read-only bit took written value");

  c_route_write: cover property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_RLINE2_RIGHT && reg_wdata[7]);
  c_pend_clears: cover property (@(posedge core_clk) disable iff (!rst_n)
    $fell(pend_flag));
  c_power_up: cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(pwr_stable));

endmodule // lomc_regs

//--- tb/lomc_host.sv
// Host model that drives the register port of the line-output mixer bank.
// Assumes strobes are sampled on the rising edge of core_clk; drives on the falling edge.
`timescale 1ns/10ps
module lomc_host (
  // Clock
  input  wire logic                         core_clk,
  // Register port
  output      logic [lomc_pkg::ADDR_W-1:0]  reg_addr,
  output      logic                         reg_wr,
  output      logic [lomc_pkg::REG_W-1:0]   reg_wdata,
  output      logic                         reg_rd,
  input  wire logic [lomc_pkg::REG_W-1:0]   reg_rdata
);
  import lomc_pkg::*;

  // Idle bus at time zero
  initial begin
    reg_addr  = '0;
    reg_wr    = 1'b0;
    reg_wdata = '0;
    reg_rd    = 1'b0;
  end

  // One write; released lines show inverted values so stale data never looks valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = (a == ADDR_LEFT_LEVEL) ? (d & 8'hfb) : d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~reg_wdata;
  endtask

  // One read; data is taken once the registered answer has settled
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask
endmodule // lomc_host

//--- tb/tb.sv
// Self-checking bench for the line-output mixer register bank.
// Assumes a short gain step period so ramps finish quickly.
`timescale 1ns/10ps
module tb;
  import lomc_pkg::*;
  localparam int STEP = 2;
  logic                    core_clk;
  logic                    rst_n;
  logic                    pwr_pin;
  logic [ADDR_W-1:0]       reg_addr;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [REG_W-1:0]        reg_wdata;
  logic [REG_W-1:0]        reg_rdata;
  logic [REG_W-1:0]        d;
  logic [NROUTE-1:0]       route_en;
  logic [NROUTE*VOL_W-1:0] route_vol;
  logic [LVL_W-1:0]        lvl;
  logic                    unmute;
  int                      fail_count;
  int                      cmp_count;
  int                      j;
  logic [ADDR_W-1:0]       addrs [NPATH] = '{ADDR_RIN_AMP_LEFT, ADDR_RDAC_LEFT,
    ADDR_LEFT_LEVEL, ADDR_LLINE2_RIGHT, ADDR_LIN_AMP_RIGHT, ADDR_LDAC_RIGHT,
    ADDR_RLINE2_RIGHT, ADDR_RIN_AMP_RIGHT, ADDR_RDAC_RIGHT};

  lomc_regs #(.STEP_CYCLES(STEP)) i_lomc_regs (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .left_out_pwr_pin(pwr_pin), .route_en(route_en),
    .route_vol(route_vol), .left_out_level(lvl), .left_out_unmute(unmute));
  lomc_host i_lomc_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Distinct route pattern per slot; enables alternate
  function automatic logic [7:0] pat(input int i);
    return {i[0], 7'(i * 11 + 1)};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog: the tests need well under 2000 cycles
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end

  // Test sequence
  initial begin
    fail_count = 0;
    cmp_count  = 0;
    pwr_pin    = 1'b0;
    rst_n      = 1'b0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk) rst_n = 1'b1;
    // Reset values; pending flag masked since the first tick may clear it
    for (int i = 0; i < NPATH; i++) begin
      i_lomc_host.rd(addrs[i], d);
      chk((i == 2) ? (d & 8'hfd) : d, 8'h00);
    end
    // Level code kept within 0..9; status bits written as ones, only the power bit checked as ignored
    for (int i = 0; i < NPATH; i++)
      i_lomc_host.wr(addrs[i], (i == 2) ? 8'h9b : pat(i));
    for (int i = 0; i < NPATH; i++) begin
      i_lomc_host.rd(addrs[i], d);
      chk((i == 2) ? (d & 8'hfd) : d, (i == 2) ? 8'h98 : pat(i));
    end
    // After the ramps, mixer controls match the programmed fields
    repeat (300) @(negedge core_clk);
    for (int i = 0; i < NPATH; i++) begin
      j = (i < 2) ? i : i - 1;
      if (i != 2)
        chk({route_en[j], route_vol[j*VOL_W +: VOL_W]}, pat(i));
    end
    chk({lvl, 3'b000, unmute}, 8'h91);
    i_lomc_host.rd(ADDR_LEFT_LEVEL, d);
    chk(d, 8'h98);
    // A new left gain raises the pending flag until it is applied
    i_lomc_host.wr(ADDR_RDAC_LEFT, 8'h05);
    i_lomc_host.rd(ADDR_LEFT_LEVEL, d);
    chk(d & 8'h02, 8'h02);
    repeat (300) @(negedge core_clk);
    i_lomc_host.rd(ADDR_LEFT_LEVEL, d);
    chk(d, 8'h98);
    // Driver power status follows the pin through its synchroniser
    @(negedge core_clk) pwr_pin = 1'b1;
    repeat (6) @(negedge core_clk);
    i_lomc_host.rd(ADDR_LEFT_LEVEL, d);
    chk(d, 8'h99);
    // Mute and disconnect
    i_lomc_host.wr(ADDR_LEFT_LEVEL, 8'h00);
    i_lomc_host.wr(ADDR_LLINE2_RIGHT, 8'h00);
    repeat (2) @(negedge core_clk);
    chk(8'({route_en[2], unmute}), 8'h00);
    // Unmapped places read zero and take no write
    i_lomc_host.wr(7'h5d, 8'hff);
    i_lomc_host.rd(7'h5d, d);
    chk(d, 8'h00);
    i_lomc_host.rd(7'h53, d);
    chk(d, 8'h00);
    i_lomc_host.rd(ADDR_RDAC_RIGHT, d);
    chk(d, pat(8));
    tally_and_finish();
  end
endmodule // tb
